// ===== pkg/btse_defs.svh
`ifndef BTSE_DEFS_SVH
`define BTSE_DEFS_SVH
// instruction word layout (14-bit)
`define BTSE_IW 14
`define BTSE_OP_BITOP 2'h1
`define BTSE_OP_CALL 2'h2
`define BTSE_SUB_SET 2'h1
`define BTSE_SUB_SKIP_CLR 2'h2
`define BTSE_SUB_SKIP_SET 2'h3
`define BTSE_PC_W 13
`define BTSE_LIT_W 11
`define BTSE_STACK_DEPTH 8
`define BTSE_PC_RST 13'h0000
`define BTSE_PAGE_LSB 3
`endif

// ===== pkg/btse_pkg.sv
`default_nettype none
package btse_pkg;
   typedef enum logic [1:0]
   {
      BTSE_EXEC = 2'b00,
      BTSE_SQUASH = 2'b01,
      BTSE_CALL2 = 2'b10
   } btse_state_t;
endpackage
`default_nettype wire

// ===== rtl/btse_core.sv
// Functional notes
// - skip-if-clear: bit one, next instruction executes, one cycle
// - skip-if-clear: bit zero, fetched next instruction squashed to no-op, two cycles
// - squash cycle does no read, no processing, no write in any quarter
// - skip-if-set: bit one, next instruction squashed to no-op, two cycles
// - skip-if-set: bit zero, next instruction executes, one cycle
// - bit test reads file register, processes bit, no write-back, no flag change
// - set-bit forces selected bit of file register to one, one cycle
`timescale 1ns/10ps
`default_nettype none
`include "btse_defs.svh"
module btse_core
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_instr_valid,
   input wire logic [13:0] i_instr,
   input wire logic [7:0] i_file_rdata,
   input wire logic [7:0] i_pc_page_latch,
   output logic [6:0] o_file_addr,
   output logic o_file_rd,
   output logic o_file_we,
   output logic [7:0] o_file_wdata,
   output logic [12:0] o_pc,
   output logic [12:0] o_stack_top,
   output logic o_squash,
   output logic o_busy
);
   // ----------------------------------------
   // decode
   // ----------------------------------------
   logic [1:0] op;
   logic [1:0] sub;
   logic [2:0] bsel;
   logic sel_bit;
   logic is_bitop;
   logic is_call;
   btse_pkg::btse_state_t state_q;
   btse_pkg::btse_state_t state_d;
   logic [12:0] pc_q;
   logic [12:0] pc_d;
   logic [12:0] stack_q [0:`BTSE_STACK_DEPTH-1];
   logic [12:0] stack_d [0:`BTSE_STACK_DEPTH-1];
   logic [2:0] sp_q;
   logic [2:0] sp_d;
   logic [7:0] wdata_q;
   logic [7:0] wdata_d;
   logic we_q;
   logic we_d;
   logic take_skip;
   assign op = i_instr[13:12];
   assign sub = i_instr[11:10];
   assign bsel = i_instr[9:7];
   assign sel_bit = i_file_rdata[bsel];
   assign is_bitop = i_instr_valid && (state_q == btse_pkg::BTSE_EXEC) && (op == `BTSE_OP_BITOP);
   assign is_call = i_instr_valid && (state_q == btse_pkg::BTSE_EXEC) && (op == `BTSE_OP_CALL);
   assign take_skip = is_bitop && (((sub == `BTSE_SUB_SKIP_CLR) && !sel_bit) ||
                                  ((sub == `BTSE_SUB_SKIP_SET) && sel_bit));
   // ----------------------------------------
   // outputs
   // ----------------------------------------
   // squash cycle leaves the file bus idle
   assign o_file_addr = i_instr[6:0];
   assign o_file_rd = is_bitop;
   assign o_squash = (state_q == btse_pkg::BTSE_SQUASH);
   assign o_busy = (state_q != btse_pkg::BTSE_EXEC);
   assign o_file_we = we_q;
   assign o_file_wdata = wdata_q;
   assign o_pc = pc_q;
   // no underflow flag: an empty or wrapped stack shows a zeroed or overwritten slot
   assign o_stack_top = stack_q[sp_q - 3'h1];
   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb
   begin
      state_d = btse_pkg::BTSE_EXEC;
      pc_d = pc_q;
      sp_d = sp_q;
      stack_d = stack_q;
      we_d = 1'b0;
      wdata_d = wdata_q;
      if (state_q == btse_pkg::BTSE_EXEC && i_instr_valid)
      begin
         pc_d = pc_q + 13'h0001;
         if (is_call)
         begin
            // stack wraps silently on overflow, as a circular buffer
            stack_d[sp_q] = pc_q + 13'h0001;
            sp_d = sp_q + 3'h1;
            pc_d = {i_pc_page_latch[4:3], i_instr[10:0]};
            state_d = btse_pkg::BTSE_CALL2;
         end
         else if (take_skip)
            state_d = btse_pkg::BTSE_SQUASH;
         else if (is_bitop && sub == `BTSE_SUB_SET)
         begin
            we_d = 1'b1;
            wdata_d = i_file_rdata | (8'h01 << bsel);
         end
         // bit tests not taken fall through: no write, no flags
      end
      else if (state_q == btse_pkg::BTSE_SQUASH)
         pc_d = pc_q + 13'h0001;
   end
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         state_q <= btse_pkg::BTSE_EXEC;
         pc_q <= `BTSE_PC_RST;
         sp_q <= 3'h0;
         we_q <= 1'b0;
         wdata_q <= 8'h00;
         for (int i = 0; i < `BTSE_STACK_DEPTH; i++)
            stack_q[i] <= 13'h0000;
      end
      else
      begin
         state_q <= state_d;
         pc_q <= pc_d;
         sp_q <= sp_d;
         we_q <= we_d;
         wdata_q <= wdata_d;
         stack_q <= stack_d;
      end
   end
   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_clr_skip;
      @(posedge i_clk) disable iff (!i_rst_n)
      (is_bitop && sub == `BTSE_SUB_SKIP_CLR && !sel_bit) |=> o_squash ##1 !o_squash;
   endproperty
   a_clr_skip: assert property (p_clr_skip) else $error("clear-test skip missing");
   property p_clr_noskip;
      @(posedge i_clk) disable iff (!i_rst_n)
      (is_bitop && sub == `BTSE_SUB_SKIP_CLR && sel_bit) |=> !o_squash && !o_busy;
   endproperty
   a_clr_noskip: assert property (p_clr_noskip) else $error("clear-test skipped wrongly");
   property p_set_skip;
      @(posedge i_clk) disable iff (!i_rst_n)
      (is_bitop && sub == `BTSE_SUB_SKIP_SET && sel_bit) |=> o_squash;
   endproperty
   a_set_skip: assert property (p_set_skip) else $error("set-test skip missing");
   property p_set_noskip;
      @(posedge i_clk) disable iff (!i_rst_n)
      (is_bitop && sub == `BTSE_SUB_SKIP_SET && !sel_bit) |=> !o_squash;
   endproperty
   a_set_noskip: assert property (p_set_noskip) else $error("set-test skipped wrongly");
   property p_squash_idle;
      @(posedge i_clk) disable iff (!i_rst_n)
      o_squash |-> !o_file_rd && !o_file_we && $stable(o_stack_top);
   endproperty
   a_squash_idle: assert property (p_squash_idle) else $error("activity in squash cycle");
   property p_test_nowrite;
      @(posedge i_clk) disable iff (!i_rst_n)
      (is_bitop && sub[1]) |=> !o_file_we;
   endproperty
   a_test_nowrite: assert property (p_test_nowrite) else $error("bit test wrote back");
   property p_bitset;
      @(posedge i_clk) disable iff (!i_rst_n)
      (is_bitop && sub == `BTSE_SUB_SET) |=> o_file_we && o_file_wdata[$past(bsel)];
   endproperty
   a_bitset: assert property (p_bitset) else $error("bit set failed");
   property p_call;
      @(posedge i_clk) disable iff (!i_rst_n)
      is_call |=> o_busy && o_stack_top == $past(pc_q) + 13'h0001 && o_pc[10:0] == $past(i_instr[10:0]) ##1 !o_busy;
   endproperty
   a_call: assert property (p_call) else $error("call sequence wrong");
   property p_set_squash_once;
      @(posedge i_clk) disable iff (!i_rst_n)
      (is_bitop && sub == `BTSE_SUB_SKIP_SET && sel_bit) |=> o_squash ##1 !o_squash;
   endproperty
   a_set_squash_once: assert property (p_set_squash_once) else $error("set-test skip not two cycles");
   property p_squash_nowrite;
      @(posedge i_clk) disable iff (!i_rst_n)
      o_squash |=> !o_file_we;
   endproperty
   a_squash_nowrite: assert property (p_squash_nowrite) else $error("discarded instruction wrote");
   property p_busy_nord;
      @(posedge i_clk) disable iff (!i_rst_n)
      o_busy |-> !o_file_rd;
   endproperty
   a_busy_nord: assert property (p_busy_nord) else $error("file read while busy");
   property p_squash_pc;
      @(posedge i_clk) disable iff (!i_rst_n)
      o_squash |=> o_pc == $past(o_pc) + 13'h0001;
   endproperty
   a_squash_pc: assert property (p_squash_pc) else $error("squash cycle did not step pc");
   property p_clr_noskip_pc;
      @(posedge i_clk) disable iff (!i_rst_n)
      (is_bitop && sub == `BTSE_SUB_SKIP_CLR && sel_bit) |=> o_pc == $past(o_pc) + 13'h0001;
   endproperty
   a_clr_noskip_pc: assert property (p_clr_noskip_pc) else $error("clear-test not one cycle");
   property p_set_noskip_pc;
      @(posedge i_clk) disable iff (!i_rst_n)
      (is_bitop && sub == `BTSE_SUB_SKIP_SET && !sel_bit) |=> !o_busy && o_pc == $past(o_pc) + 13'h0001;
   endproperty
   a_set_noskip_pc: assert property (p_set_noskip_pc) else $error("set-test not one cycle");
   property p_test_rd;
      @(posedge i_clk) disable iff (!i_rst_n)
      (i_instr_valid && !o_busy && op == `BTSE_OP_BITOP) |-> o_file_rd && o_file_addr == i_instr[6:0];
   endproperty
   a_test_rd: assert property (p_test_rd) else $error("bit op did not read its register");
   property p_bitset_keep;
      @(posedge i_clk) disable iff (!i_rst_n)
      (is_bitop && sub == `BTSE_SUB_SET) |=>
         (((o_file_wdata ^ $past(i_file_rdata)) & ~(8'h01 << $past(bsel))) == 8'h00);
   endproperty
   a_bitset_keep: assert property (p_bitset_keep) else $error("bit set disturbed other bits");
   property p_call_nowrite;
      @(posedge i_clk) disable iff (!i_rst_n)
      is_call |=> !o_file_we ##1 !o_file_we;
   endproperty
   a_call_nowrite: assert property (p_call_nowrite) else $error("call wrote a file register");
   property p_call_page;
      @(posedge i_clk) disable iff (!i_rst_n)
      is_call |=> o_pc[12:11] == $past(i_pc_page_latch[`BTSE_PAGE_LSB+1:`BTSE_PAGE_LSB]);
   endproperty
   a_call_page: assert property (p_call_page) else $error("call page bits wrong");
endmodule
`default_nettype wire

// ===== verif/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_instr_valid = 1'b0;
   logic [13:0] i_instr = 14'h0000;
   logic [7:0] i_file_rdata = 8'h00;
   logic [7:0] i_pc_page_latch = 8'h18;
   logic [6:0] o_file_addr;
   logic o_file_rd, o_file_we, o_squash, o_busy;
   logic [7:0] o_file_wdata;
   logic [12:0] o_pc, o_stack_top, pc;
   int bad_count = 0;
   int num_checks = 0;
   always #5 i_clk = ~i_clk;
   btse_core dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_instr_valid(i_instr_valid), .i_instr(i_instr),
      .i_file_rdata(i_file_rdata), .i_pc_page_latch(i_pc_page_latch), .o_file_addr(o_file_addr),
      .o_file_rd(o_file_rd), .o_file_we(o_file_we), .o_file_wdata(o_file_wdata), .o_pc(o_pc),
      .o_stack_top(o_stack_top), .o_squash(o_squash), .o_busy(o_busy));
   task automatic chk(input string n, input logic [12:0] s, input logic [12:0] e);
      num_checks++;
      if (s !== e)
      begin
         bad_count++;
         $display("wrong value %s exp %h seen %h", n, e, s);
      end
   endtask
   // drive at the edge, then look half a cycle later once it has settled
   task automatic give(input logic v, input logic [13:0] ins, input logic [7:0] rd);
      @(posedge i_clk);
      i_instr_valid <= v;
      i_instr <= ins;
      i_file_rdata <= rd;
      @(negedge i_clk);
   endtask
   // the follower is a set of bit 7 on register 0x11 holding 0x0A: it shows whether it ran or was squashed
   task automatic skip_test(input logic [1:0] sub, input logic [2:0] b, input logic val, input logic skip);
      logic [7:0] rd;
      rd = val ? (8'h01 << b) : ~(8'h01 << b);
      give(1'b1, {2'h1, sub, b, 7'h2A}, rd);
      chk("file_rd", 13'(o_file_rd), 13'h0001);
      chk("file_addr", 13'(o_file_addr), 13'h002A);
      give(1'b1, {4'h5, 3'h7, 7'h11}, 8'h0A);
      chk("squash", 13'(o_squash), 13'(skip));
      chk("busy", 13'(o_busy), 13'(skip));
      chk("squash_rd", 13'(o_file_rd), 13'(!skip));
      chk("test_we", 13'(o_file_we), 13'h0000);
      give(1'b0, 14'h0000, 8'h00);
      chk("next_we", 13'(o_file_we), 13'(!skip));
      if (!skip)
      begin
         chk("wdata", 13'(o_file_wdata), 13'h008A);
      end
      chk("squash_end", 13'(o_squash), 13'h0000);
      pc = pc + 13'h0002;
      chk("pc", o_pc, pc);
   endtask
   task automatic call_test;
      give(1'b1, {3'h4, 11'h5A5}, 8'h00);
      give(1'b1, {4'h5, 3'h0, 7'h11}, 8'h00);
      chk("call_busy", 13'(o_busy), 13'h0001);
      chk("call_pc", o_pc, {2'h3, 11'h5A5});
      chk("stack_top", o_stack_top, pc + 13'h0001);
      give(1'b0, 14'h0000, 8'h00);
      chk("call_busy2", 13'(o_busy), 13'h0000);
      chk("call_we", 13'(o_file_we), 13'h0000);
   endtask
   task automatic test_clr_bit_one;
      skip_test(2'h2, 3'h3, 1'b1, 1'b0);
   endtask
   task automatic test_clr_bit_zero;
      skip_test(2'h2, 3'h0, 1'b0, 1'b1);
   endtask
   task automatic test_set_bit_one;
      skip_test(2'h3, 3'h5, 1'b1, 1'b1);
   endtask
   task automatic test_set_bit_zero;
      skip_test(2'h3, 3'h7, 1'b0, 1'b0);
   endtask
   // a call held on the bus during reset must not survive it
   task automatic reset_test;
      @(posedge i_clk);
      i_rst_n <= 1'b0;
      i_instr_valid <= 1'b1;
      i_instr <= {3'h4, 11'h123};
      repeat (2) @(posedge i_clk);
      i_rst_n <= 1'b1;
      i_instr_valid <= 1'b0;
      @(negedge i_clk);
      chk("rst_pc", o_pc, 13'h0000);
      chk("rst_busy", 13'(o_busy), 13'h0000);
      chk("rst_squash", 13'(o_squash), 13'h0000);
      chk("rst_we", 13'(o_file_we), 13'h0000);
      chk("rst_stack", o_stack_top, 13'h0000);
      pc = 13'h0000;
   endtask
   task automatic close_out;
      if (bad_count == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      pc = 13'h0000;
      repeat (12) @(posedge i_clk);
      i_rst_n <= 1'b1;
      test_clr_bit_one;
      test_clr_bit_zero;
      test_set_bit_one;
      test_set_bit_zero;
      call_test;
      reset_test;
      test_set_bit_one;
      close_out;
   end
   initial
   begin
      repeat (500) @(posedge i_clk);
      bad_count++;
      close_out;
   end
endmodule
`default_nettype wire
